/* usa_pkg.sv */
// Purpose: Shared constants and frame helpers for the serial channel ends
// Assumes: One 125 MHz clock per end, active-low async reset
// Notes:   Register offsets are indices on the plain register port
package usa_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [2:0] ADR_DATA  = 3'h0;
   localparam logic [2:0] ADR_STAT  = 3'h1;
   localparam logic [2:0] ADR_CTLB  = 3'h2;
   localparam logic [2:0] ADR_FMT   = 3'h3;
   localparam logic [2:0] ADR_BAUDL = 3'h4;
   localparam logic [2:0] ADR_BAUDH = 3'h5;

   localparam int         B_TXC     = 6;
   localparam logic [7:0] CTLB_RST  = 8'h00;
   localparam logic [7:0] FMT_RST   = 8'h06;
   localparam logic [7:0] STAT_RST  = 8'h00;
   localparam logic [11:0] BAUD_RST = 12'h000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [3:0] OS_NORM = 4'hF;
   localparam logic [3:0] OS_DBL  = 4'h7;
   localparam int         FRAME_W = 13;

   // ----------------------------------------
   // Frame helpers
   // ----------------------------------------
   function automatic logic [3:0] usa_char_len(input logic [2:0] code);
      case (code)
         3'h0:    usa_char_len = 4'h5;
         3'h1:    usa_char_len = 4'h6;
         3'h2:    usa_char_len = 4'h7;
         3'h7:    usa_char_len = 4'h9;
         default: usa_char_len = 4'h8;
      endcase
   endfunction

   function automatic logic [8:0] usa_mask(input logic [3:0] n);
      logic [8:0] m;
      m = 9'h000;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) m[i] = 1'b1;
      end
      return m;
   endfunction

   function automatic logic [FRAME_W-1:0] usa_frame(input logic [8:0] d,
                                                    input logic [3:0] n,
                                                    input logic [1:0] pm);
      logic [FRAME_W-1:0] f;
      logic [8:0]         dm;
      dm   = d & usa_mask(n);
      f    = '1;
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) f[i+1] = dm[i];
      end
      if (pm[1]) f[n+4'h1] = ^dm ^ pm[0];
      return f;
   endfunction

   function automatic logic [3:0] usa_flen(input logic [3:0] n,
                                           input logic       par,
                                           input logic       two);
      return n + {3'h0, par} + {3'h0, two} + 4'h2;
   endfunction

endpackage

/* usa_link_if.sv */
// Purpose: Serial link between the channel and the remote serial device
// Assumes: Undriven data lines idle high, undriven sync clock low
// Notes:   Resolves the released transmit and clock pins
interface usa_link_if;
   logic txd;
   logic txd_oe;
   logic sck;
   logic sck_oe;
   logic rxd;
   logic txd_line;
   logic sck_line;

   assign txd_line = txd_oe ? txd : 1'b1;
   assign sck_line = sck_oe ? sck : 1'b0;

   modport dev (output txd, output txd_oe, output sck, output sck_oe, input rxd);
   modport far (input txd_line, input sck_line, output rxd);
endinterface

/* usa_far.sv */
// Purpose: Remote serial device: frames out on rxd, frames in from txd
// Assumes: Format set on plain inputs; sync mode slaves to link clock
// Notes:   Link clock half period must exceed three local cycles
module usa_far
   import usa_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] bit_cycles_i,
   input  wire logic [3:0]  data_bits_i,
   input  wire logic [1:0]  parity_i,
   input  wire logic        two_stop_i,
   input  wire logic        sync_i,
   input  wire logic        pol_i,
   input  wire logic        send_i,
   input  wire logic [8:0]  send_data_i,
   output logic             send_ready_o,
   output logic             recv_valid_o,
   output logic      [8:0]  recv_data_o,
   output logic             recv_fe_o,
   output logic             recv_pe_o,
   usa_link_if.far          link
);
   logic [2:0]         tx_s, ck_s;
   logic               rise, fall, chg, smp;
   logic [FRAME_W-1:0] tsh_q;
   logic [3:0]         tcnt_q, ridx_q, rlast;
   logic [15:0]        ttm_q, rtm_q;
   logic               tstep, rbusy_q, rchk_q, rsamp;
   logic [11:0]        rsh_q;
   logic [8:0]         rdat;

   // ----------------------------------------
   // Pin synchronisers and link clock edges
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_s <= 3'h7;
         ck_s <= 3'h0;
      end else begin
         tx_s <= {tx_s[1:0], link.txd_line};
         ck_s <= {ck_s[1:0], link.sck_line};
      end
   end

   assign rise  = sync_i & ck_s[1] & !ck_s[2];
   assign fall  = sync_i & !ck_s[1] & ck_s[2];
   assign chg   = pol_i ? fall : rise;
   assign smp   = pol_i ? rise : fall;

   // ----------------------------------------
   // Transmit toward the channel
   // ----------------------------------------
   assign send_ready_o = (tcnt_q == 4'h0);
   assign tstep        = sync_i ? chg : (ttm_q == bit_cycles_i - 16'h1);
   assign link.rxd     = tsh_q[0];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tsh_q  <= '1;
         tcnt_q <= 4'h0;
         ttm_q  <= 16'h0;
      end else if (send_i && send_ready_o) begin
         tsh_q  <= usa_frame(send_data_i, data_bits_i, parity_i);
         tcnt_q <= usa_flen(data_bits_i, parity_i[1], two_stop_i);
         ttm_q  <= 16'h0;
      end else if (!send_ready_o) begin
         ttm_q <= tstep ? 16'h0 : ttm_q + 16'h1;
         if (tstep) begin
            tsh_q  <= {1'b1, tsh_q[FRAME_W-1:1]};
            tcnt_q <= tcnt_q - 4'h1;
         end
      end
   end

   // ----------------------------------------
   // Receive from the channel
   // ----------------------------------------
   assign rlast = data_bits_i + {3'h0, parity_i[1]};
   assign rsamp = sync_i ? smp : (rtm_q == bit_cycles_i - 16'h1);
   assign rdat  = rsh_q[8:0] & usa_mask(data_bits_i);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rbusy_q      <= 1'b0;
         rchk_q       <= 1'b0;
         rtm_q        <= 16'h0;
         ridx_q       <= 4'h0;
         rsh_q        <= 12'h000;
         recv_valid_o <= 1'b0;
         recv_data_o  <= 9'h000;
         recv_fe_o    <= 1'b0;
         recv_pe_o    <= 1'b0;
      end else begin
         recv_valid_o <= 1'b0;
         if (!rbusy_q) begin
            if (!tx_s[2] && (!sync_i || smp)) begin
               rbusy_q <= 1'b1;
               rchk_q  <= !sync_i;
               rtm_q   <= 16'h0;
               ridx_q  <= 4'h0;
            end
         end else if (rchk_q) begin
            rtm_q <= rtm_q + 16'h1;
            if (rtm_q == (bit_cycles_i >> 1)) begin
               rtm_q   <= 16'h0;
               rchk_q  <= 1'b0;
               rbusy_q <= !tx_s[2];
            end
         end else begin
            rtm_q <= rsamp ? 16'h0 : rtm_q + 16'h1;
            if (rsamp) begin
               rsh_q[ridx_q] <= tx_s[2];
               ridx_q        <= ridx_q + 4'h1;
               if (ridx_q == rlast) begin
                  rbusy_q      <= 1'b0;
                  recv_valid_o <= 1'b1;
               end
            end
         end
         if (recv_valid_o) begin
            recv_data_o <= rdat;
            recv_fe_o   <= !rsh_q[rlast];
            recv_pe_o   <= parity_i[1] & (^rdat ^ parity_i[0] ^ rsh_q[data_bits_i]);
         end
      end
   end
endmodule

/* usa_dev.sv */
// Purpose: Serial channel with data port, status/control and frame engines
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Reserved size codes act as eight bits; sync mode drives the clock
//
// Chosen here: the address map and the address-and-strobe port.
module usa_dev
   import usa_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       gie_i,
   input  wire logic       tx_done_ack_i,
   output logic            rx_done_irq_o,
   output logic            tx_done_irq_o,
   output logic            tx_empty_irq_o,
   output logic            rx_pin_owned_o,
   usa_link_if.dev         link
);
   logic               u2x_q, mpcm_q, rx_on_q, tx_on_q, csz2_q, tx9_q;
   logic               umsel_q, usbs_q, pol_q, txc_q, dor_q;
   logic [2:0]         ie_q;
   logic [1:0]         upm_q, csz_q;
   logic [11:0]        baud_q, pre_q;
   logic [3:0]         nbits, os_max, rlast;
   logic               tick, sck_q, tx_edge, rx_edge;
   logic               hold_v_q, tbusy, tx_act, tx_step, load, txc_set, txc_clr;
   logic [8:0]         hold_q;
   logic [FRAME_W-1:0] tsh_q;
   logic [3:0]         tcnt_q, tos_q;
   logic               rx_s1, rx_s2, rbusy_q, rchk_q, rdone_q, rsamp, start_det;
   logic [3:0]         ros_q, ridx_q;
   logic [11:0]        rsh_q;
   logic [8:0]         rdat;
   logic [10:0]        new_ent, pend_q, head;
   logic               addr_ind, new_ok, pop, space, do_push, pend_v_q;
   logic [10:0]        ent_q [2];
   logic               rd_q;
   logic [1:0]         cnt_q;
   logic               wr_data, wr_stat;

   assign wr_data = wr_i && (addr_i == ADR_DATA);
   assign wr_stat = wr_i && (addr_i == ADR_STAT);
   assign nbits   = usa_char_len({csz2_q, csz_q});
   assign os_max  = (u2x_q && !umsel_q) ? OS_DBL : OS_NORM;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {u2x_q, mpcm_q} <= STAT_RST[1:0];
         {ie_q, rx_on_q, tx_on_q, csz2_q} <= CTLB_RST[7:2];
         tx9_q   <= CTLB_RST[0];
         umsel_q <= FMT_RST[6];
         upm_q   <= FMT_RST[5:4];
         usbs_q  <= FMT_RST[3];
         csz_q   <= FMT_RST[2:1];
         pol_q   <= FMT_RST[0];
         baud_q  <= BAUD_RST;
      end else if (wr_i) begin
         case (addr_i)
            ADR_STAT:  {u2x_q, mpcm_q} <= wdata_i[1:0];
            ADR_CTLB: begin
               {ie_q, rx_on_q, tx_on_q, csz2_q} <= wdata_i[7:2];
               tx9_q <= wdata_i[0];
            end
            ADR_FMT: begin
               umsel_q <= wdata_i[6];
               upm_q   <= wdata_i[5:4];
               usbs_q  <= wdata_i[3];
               csz_q   <= wdata_i[2:1];
               pol_q   <= wdata_i[0];
            end
            ADR_BAUDL: baud_q[7:0]  <= wdata_i;
            ADR_BAUDH: baud_q[11:8] <= wdata_i[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Baud prescaler and sync clock
   // ----------------------------------------
   assign tick    = (pre_q == 12'h000);
   assign tx_edge = tick & umsel_q & (pol_q ? sck_q : !sck_q);
   assign rx_edge = tick & umsel_q & (pol_q ? !sck_q : sck_q);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_q <= BAUD_RST;
         sck_q <= 1'b0;
      end else begin
         if (wr_i && addr_i == ADR_BAUDL) pre_q <= {baud_q[11:8], wdata_i};
         else if (tick) pre_q <= baud_q;
         else pre_q <= pre_q - 12'h001;
         sck_q <= umsel_q ? sck_q ^ tick : 1'b0;
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   assign tbusy   = (tcnt_q != 4'h0);
   assign tx_act  = tx_on_q | tbusy | hold_v_q;
   assign tx_step = umsel_q ? tx_edge : (tick && tos_q == os_max);
   assign load    = tx_on_q & !tbusy & hold_v_q;
   assign txc_set = tbusy & tx_step & (tcnt_q == 4'h1) & !hold_v_q;
   assign txc_clr = tx_done_ack_i | (wr_stat & wdata_i[B_TXC]);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_v_q <= 1'b0;
         hold_q   <= 9'h000;
      end else if (load) begin
         hold_v_q <= 1'b0;
      end else if (wr_data && !hold_v_q) begin
         hold_v_q <= 1'b1;
         hold_q   <= {tx9_q, wdata_i};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tsh_q  <= '1;
         tcnt_q <= 4'h0;
         tos_q  <= 4'h0;
      end else if (load) begin
         tsh_q  <= usa_frame(hold_q, nbits, upm_q);
         tcnt_q <= usa_flen(nbits, upm_q[1], usbs_q);
         tos_q  <= 4'h0;
      end else if (tbusy) begin
         if (tick && !umsel_q) tos_q <= (tos_q == os_max) ? 4'h0 : tos_q + 4'h1;
         if (tx_step) begin
            tsh_q  <= {1'b1, tsh_q[FRAME_W-1:1]};
            tcnt_q <= tcnt_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) txc_q <= 1'b0;
      else if (txc_set) txc_q <= 1'b1;
      else if (txc_clr) txc_q <= 1'b0;
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   assign rlast     = nbits + {3'h0, upm_q[1]};
   assign rsamp     = umsel_q ? rx_edge : (tick && ros_q == os_max);
   assign start_det = rx_on_q & !rbusy_q & !rx_s2 & (umsel_q ? rx_edge : tick);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= link.rxd;
         rx_s2 <= rx_s1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rbusy_q <= 1'b0;
         rchk_q  <= 1'b0;
         rdone_q <= 1'b0;
         ros_q   <= 4'h0;
         ridx_q  <= 4'h0;
         rsh_q   <= 12'h000;
      end else begin
         rdone_q <= 1'b0;
         if (!rx_on_q) begin
            rbusy_q <= 1'b0;
         end else if (start_det) begin
            rbusy_q <= 1'b1;
            rchk_q  <= !umsel_q;
            ros_q   <= 4'h0;
            ridx_q  <= 4'h0;
         end else if (rbusy_q && rchk_q) begin
            // Mid start bit recheck rejects glitches
            if (tick) ros_q <= ros_q + 4'h1;
            if (tick && ros_q == (os_max >> 1)) begin
               ros_q   <= 4'h0;
               rchk_q  <= 1'b0;
               rbusy_q <= !rx_s2;
            end
         end else if (rbusy_q) begin
            if (tick && !umsel_q) ros_q <= (ros_q == os_max) ? 4'h0 : ros_q + 4'h1;
            if (rsamp) begin
               rsh_q[ridx_q] <= rx_s2;
               ridx_q        <= ridx_q + 4'h1;
               if (ridx_q == rlast) begin
                  rbusy_q <= 1'b0;
                  rdone_q <= 1'b1;
               end
            end
         end
      end
   end

   always_comb begin
      rdat     = rsh_q[8:0] & usa_mask(nbits);
      new_ent  = {upm_q[1] & (^rdat ^ upm_q[0] ^ rsh_q[nbits]), !rsh_q[rlast], rdat};
      addr_ind = (nbits == 4'h9) ? rdat[8] : rsh_q[rlast];
   end

   assign new_ok  = rdone_q & rx_on_q & (!mpcm_q | addr_ind);

   // ----------------------------------------
   // Receive FIFO
   // ----------------------------------------
   // A data read advances unless the FIFO is empty
   assign pop     = rd_i && (addr_i == ADR_DATA) && (cnt_q != 2'h0);
   assign space   = (cnt_q != 2'h2) || pop;
   assign do_push = (pend_v_q | new_ok) & space;
   assign head    = (cnt_q != 2'h0) ? ent_q[rd_q] : 11'h000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ent_q[0] <= 11'h000;
         ent_q[1] <= 11'h000;
         rd_q     <= 1'b0;
         cnt_q    <= 2'h0;
         pend_q   <= 11'h000;
         pend_v_q <= 1'b0;
      end else if (!rx_on_q) begin
         cnt_q    <= 2'h0;
         pend_v_q <= 1'b0;
      end else begin
         if (do_push) ent_q[rd_q ^ cnt_q[0]] <= pend_v_q ? pend_q : new_ent;
         if (pop) rd_q <= !rd_q;
         cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, pop};
         if (new_ok && (pend_v_q || !space)) begin
            pend_q   <= new_ent;
            pend_v_q <= 1'b1;
         end else if (pend_v_q && space) begin
            pend_v_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) dor_q <= 1'b0;
      else if (!rx_on_q) dor_q <= 1'b0;
      else if (start_det && cnt_q == 2'h2 && pend_v_q) dor_q <= 1'b1;
      else if (pop) dor_q <= 1'b0;
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            ADR_DATA:  rdata_o <= head[7:0];
            ADR_STAT:  rdata_o <= {cnt_q != 2'h0, txc_q, !hold_v_q, head[9], dor_q,
                                   head[10], u2x_q, mpcm_q};
            ADR_CTLB:  rdata_o <= {ie_q, rx_on_q, tx_on_q, csz2_q, head[8], tx9_q};
            ADR_FMT:   rdata_o <= {1'b0, umsel_q, upm_q, usbs_q, csz_q, pol_q};
            ADR_BAUDL: rdata_o <= baud_q[7:0];
            ADR_BAUDH: rdata_o <= {4'h0, baud_q[11:8]};
            default:   rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------
   // Requests and pins
   // ----------------------------------------
   // Enable, global enable and flag
   assign rx_done_irq_o  = ie_q[2] & gie_i & (cnt_q != 2'h0);
   assign tx_done_irq_o  = ie_q[1] & gie_i & txc_q;
   assign tx_empty_irq_o = ie_q[0] & gie_i & !hold_v_q;
   assign rx_pin_owned_o = rx_on_q;
   assign link.txd       = tsh_q[0];
   assign link.txd_oe    = tx_act;
   assign link.sck       = sck_q;
   assign link.sck_oe    = umsel_q & (tx_act | rx_on_q);
endmodule

/* usa_chan_props.sv */
// Purpose: Assertions on the serial link and the register port
// Assumes: One clock, reset asynchronous and active low
// Notes:   Takes the link lines as plain inputs, no bind
module usa_chan_props
   import usa_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       txd_line,
   input wire logic       txd_oe,
   input wire logic [2:0] addr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       gie_i,
   input wire logic       rx_done_irq_o,
   input wire logic       tx_empty_irq_o,
   input wire logic       rx_pin_owned_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ------------
   // Properties
   // ------------
   // Shortest async bit is eight clocks
   sequence s_fall;
      $fell(txd_line);
   endsequence
   sequence s_low_bit;
      !txd_line [*8];
   endsequence
   chk_bit_low_width: assert property (s_fall |-> s_low_bit)
      else $error("low bit too short");
   chk_line_idle_high: assert property (!txd_oe |-> txd_line)
      else $error("released line not high");
   chk_oe_at_idle: assert property ($fell(txd_oe) |-> $past(txd_line))
      else $error("pin released mid frame");
   chk_reset_quiet: assert property ($rose(rst_n_i) |-> !txd_oe && !rx_pin_owned_o)
      else $error("pins owned after reset");
   chk_read_slot: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   chk_baud_high_zero: assert property
      (rd_i && addr_i == ADR_BAUDH |=> rdata_o[7:4] == 4'h0)
      else $error("baud high upper bits set");
   chk_rx_irq_gate: assert property (rx_done_irq_o |-> gie_i && rx_pin_owned_o)
      else $error("rx irq without enables");
   chk_empty_irq_gate: assert property (tx_empty_irq_o |-> gie_i)
      else $error("empty irq without global enable");
endmodule

/* tb_usa_dev.sv */
// Purpose: Bench joining the channel to the remote serial device
// Assumes: 125 MHz clock, fixed seed, reset held 20 cycles
// Notes:   Expected characters come from the bench's own masks
module tb_usa_dev
   import usa_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, gie_i = 1'b0;
   logic        ack = 1'b0, send = 1'b0, two = 1'b0, rdy, rv, ffe, fpe, rxi, txi, tei, own, h;
   logic [2:0]  addr_i = 3'h0;
   logic [7:0]  wdata_i = 8'h00, rdata_o, r, cb;
   logic [8:0]  sdat = 9'h000, rdat, d;
   logic [15:0] bitc = 16'h0010;
   logic [3:0]  nb = 4'h8;
   logic [1:0]  par = 2'h0;
   logic [2:0]  szs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   logic [1:0]  pms [3] = '{2'h0, 2'h2, 2'h3};
   int          n_fail = 0, num_checks = 0, cyc = 0, n_rx = 0;
   usa_link_if  link ();
   usa_dev i_usa_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gie_i(gie_i), .tx_done_ack_i(ack),
      .rx_done_irq_o(rxi), .tx_done_irq_o(txi), .tx_empty_irq_o(tei),
      .rx_pin_owned_o(own), .link(link.dev));
   usa_far i_usa_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .bit_cycles_i(bitc), .data_bits_i(nb),
      .parity_i(par), .two_stop_i(two), .sync_i(1'b0), .pol_i(1'b0), .send_i(send),
      .send_data_i(sdat), .send_ready_o(rdy), .recv_valid_o(rv), .recv_data_o(rdat),
      .recv_fe_o(ffe), .recv_pe_o(fpe), .link(link.far));
   usa_chan_props i_usa_chan_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .txd_line(link.txd_line), .txd_oe(link.txd_oe), .addr_i(addr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .gie_i(gie_i), .rx_done_irq_o(rxi), .tx_empty_irq_o(tei),
      .rx_pin_owned_o(own));
   // ------------
   // Clock, watchdog, tasks
   // ------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (rv === 1'b1) n_rx <= n_rx + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 r = rdata_o;
   endtask
   // Bounded wait: 0 rx done, 1 tx done, 2 far got frame, 3 far ready
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while ((k == 0 ? rxi : k == 1 ? txi : k == 2 ? rv : rdy) !== 1'b1 && n < 5000);
      chk(n < 5000, 1'b1);
   endtask
   task automatic far_send(input logic [8:0] v);
      wait_hi(3);
      send <= 1'b1;
      sdat <= v;
      @(posedge clk_i);
      send <= 1'b0;
   endtask
   task automatic cfg(input logic [2:0] sz, input logic [1:0] pm, input logic dv, b, t);
      // Writing one to bit 6 also clears a stale tx done
      wreg(ADR_STAT, {6'h10, dv, 1'b0});
      wreg(ADR_BAUDL, {7'h00, b});
      wreg(ADR_FMT, {2'h0, pm, t, sz[1:0], 1'b0});
      cb = {5'h1B, sz[2], 2'h0};
      wreg(ADR_CTLB, cb);
      nb   <= (sz == 3'h7) ? 4'h9 : 4'h5 + {1'b0, sz};
      par  <= pm;
      two  <= t;
      bitc <= (dv ? 16'h0008 : 16'h0010) * (16'h0001 + b);
   endtask
   // ------------
   // Main sequence
   // ------------
   initial begin
      void'($urandom(27974));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rreg(ADR_STAT);
      chk(r, 8'h20);
      rreg(ADR_FMT);
      chk(r, FMT_RST);
      rreg(ADR_BAUDH);
      chk(r, 8'h00);
      rreg(3'h6);
      chk(r, 8'h00);
      $display("test reset done");
      // Transmitter off: second write must be dropped
      wreg(ADR_DATA, 8'hA5);
      wreg(ADR_DATA, 8'h3C);
      rreg(ADR_STAT);
      chk(r[5], 1'b0);
      gie_i <= 1'b1;
      cb = 8'hD8;
      wreg(ADR_CTLB, cb);
      wait_hi(2);
      @(posedge clk_i);
      #1 chk(rdat, 9'h0A5);
      chk(own, 1'b1);
      wait_hi(1);
      chk(9'(n_rx), 9'h001);
      ack <= 1'b1;
      @(posedge clk_i);
      ack <= 1'b0;
      rreg(ADR_STAT);
      chk(r[6:5], 2'b01);
      $display("test drop done");
      for (int i = 0; i < 15; i++) begin
         cfg(szs[i % 5], pms[i / 5], i >= 10, i[0], 1'($urandom));
         d = 9'($urandom);
         far_send(d);
         wait_hi(0);
         rreg(ADR_STAT);
         chk(r & 8'h94, 8'h80);
         rreg(ADR_CTLB);
         h = r[1];
         rreg(ADR_DATA);
         chk({h, r}, d & (9'h1FF >> (4'h9 - nb)));
         d = 9'($urandom);
         wreg(ADR_CTLB, cb | {7'h00, d[8]});
         wreg(ADR_DATA, d[7:0]);
         wait_hi(2);
         @(posedge clk_i);
         #1 chk(rdat, d & (9'h1FF >> (4'h9 - nb)));
         chk({ffe, fpe}, 2'b00);
         wait_hi(1);
      end
      $display("test formats done");
      cfg(3'h3, 2'h2, 1'b0, 1'b0, 1'b0);
      par <= 2'h3;
      far_send(9'h0C3);
      wait_hi(0);
      rreg(ADR_STAT);
      chk(r & 8'h94, 8'h84);
      rreg(ADR_DATA);
      rreg(ADR_STAT);
      chk(r & 8'h84, 8'h00);
      par <= 2'h2;
      repeat (4) far_send(9'($urandom));
      wait_hi(3);
      rreg(ADR_STAT);
      chk(r & 8'h88, 8'h88);
      wreg(ADR_CTLB, 8'h48);
      rreg(ADR_STAT);
      chk(r & 8'h9C, 8'h00);
      chk(own, 1'b0);
      $display("test errors done");
      // Nine-bit frames, filter on: only the marked one lands
      cfg(3'h7, 2'h0, 1'b0, 1'b0, 1'b0);
      wreg(ADR_STAT, 8'h41);
      far_send(9'h055);
      far_send(9'h1AA);
      wait_hi(0);
      rreg(ADR_CTLB);
      h = r[1];
      rreg(ADR_DATA);
      chk({h, r}, 9'h1AA);
      rreg(ADR_STAT);
      chk(r[7], 1'b0);
      $display("test filter done");
      wreg(ADR_CTLB, 8'h28);
      gie_i <= 1'b0;
      @(posedge clk_i);
      #1 chk(tei, 1'b0);
      gie_i <= 1'b1;
      @(posedge clk_i);
      #1 chk(tei, 1'b1);
      wreg(ADR_CTLB, 8'h00);
      #1 chk(tei, 1'b0);
      $display("test irq done");
      summarize();
   end
endmodule
